// ### verilog/accel_sample_readout_regs.v
// acceleration sample readout registers with low/high shadow lock behind an apb slave
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "accel_readout_defines.vh"

// Contract
// - low read freezes high until high read
// - upward burst reads lock automatically
// - high register returns sample bits 11:4
// - low register bits 7:4 hold sample 3:0
// - low bits 3:1 undefined, host ignores
// - fresh bit 1 after update since readout
// - fresh bit 0 after readout, no update
// - x low same layout as others
// - z high bits 11:4, same lock
module accel_sample_readout_regs (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire [3:0] pstrb_i,
	output wire pready_o,
	output reg [31:0] prdata_o,
	output reg pslverr_o,
	input wire [11:0] sample_x_i,
	input wire [11:0] sample_y_i,
	input wire [11:0] sample_z_i,
	input wire [2:0] sample_valid_i,
	output wire irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// bus decode

	wire [5:0] idx;
	wire setup_phase;
	wire access_rd;
	wire access_wr;

	assign idx = paddr_i[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
	// zero wait states: every access completes in its first access cycle
	assign pready_o = 1'b1;
	assign setup_phase = psel_i & ~penable_i;
	assign access_rd = psel_i & penable_i & ~pwrite_i;
	assign access_wr = psel_i & penable_i & pwrite_i;

	////////////////////////////////////////////////////////////////////////////////
	// control and interrupt registers

	reg lock_off_q;
	reg [2:0] irq_status_q;
	reg [2:0] irq_enable_q;
	reg [2:0] irq_status_d;
	wire wr_ctrl;
	wire wr_clear;
	wire wr_enable;

	assign wr_ctrl = access_wr & (idx == `IDX_CTRL) & pstrb_i[0];
	assign wr_clear = access_wr & (idx == `IDX_IRQ_CLEAR) & pstrb_i[0];
	assign wr_enable = access_wr & (idx == `IDX_IRQ_ENABLE) & pstrb_i[0];

	// new sample events are sticky; a set in the clear cycle survives
	always @* begin
		irq_status_d = irq_status_q;
		if (wr_clear) begin
			irq_status_d = irq_status_d & ~pwdata_i[2:0];
		end
		irq_status_d = irq_status_d | sample_valid_i;
	end

	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lock_off_q <= `RST_LOCK_OFF;
			irq_status_q <= `RST_IRQ;
			irq_enable_q <= `RST_IRQ;
		end else begin
			irq_status_q <= irq_status_d;
			if (wr_ctrl) begin
				lock_off_q <= pwdata_i[`CTRL_LOCK_OFF_BIT];
			end
			if (wr_enable) begin
				irq_enable_q <= pwdata_i[2:0];
			end
		end
	end

	// level interrupt while any enabled event is pending
	assign irq_o = |(irq_status_q & irq_enable_q);

	////////////////////////////////////////////////////////////////////////////////
	// per-axis decode and axis slots

	wire x_low_setup;
	wire x_low_read;
	wire x_high_read;
	wire y_low_setup;
	wire y_low_read;
	wire y_high_read;
	wire z_low_setup;
	wire z_low_read;
	wire z_high_read;
	wire [7:0] x_low_byte;
	wire [7:0] x_high_byte;
	wire [7:0] y_low_byte;
	wire [7:0] y_high_byte;
	wire [7:0] z_low_byte;
	wire [7:0] z_high_byte;

	// frozen copy is taken at setup, in the cycle the low byte is sampled
	assign x_low_setup = setup_phase & ~pwrite_i & (idx == `IDX_X_LOW);
	assign y_low_setup = setup_phase & ~pwrite_i & (idx == `IDX_Y_LOW);
	assign z_low_setup = setup_phase & ~pwrite_i & (idx == `IDX_Z_LOW);

	// an upward burst hits each low index before its high one
	assign x_low_read = access_rd & (idx == `IDX_X_LOW);
	assign y_low_read = access_rd & (idx == `IDX_Y_LOW);
	assign z_low_read = access_rd & (idx == `IDX_Z_LOW);

	// any read access of a high index releases that axis
	assign x_high_read = access_rd & (idx == `IDX_X_HIGH);
	assign y_high_read = access_rd & (idx == `IDX_Y_HIGH);
	assign z_high_read = access_rd & (idx == `IDX_Z_HIGH);

	// x axis slot
	accel_axis_slot u_x_slot (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.load_i(sample_valid_i[0]),
		.sample_i(sample_x_i),
		.low_setup_i(x_low_setup),
		.low_read_i(x_low_read),
		.high_read_i(x_high_read),
		.lock_off_i(lock_off_q),
		.low_byte_o(x_low_byte),
		.high_byte_o(x_high_byte)
	);

	// y axis slot
	accel_axis_slot u_y_slot (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.load_i(sample_valid_i[1]),
		.sample_i(sample_y_i),
		.low_setup_i(y_low_setup),
		.low_read_i(y_low_read),
		.high_read_i(y_high_read),
		.lock_off_i(lock_off_q),
		.low_byte_o(y_low_byte),
		.high_byte_o(y_high_byte)
	);

	// z axis slot
	accel_axis_slot u_z_slot (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.load_i(sample_valid_i[2]),
		.sample_i(sample_z_i),
		.low_setup_i(z_low_setup),
		.low_read_i(z_low_read),
		.high_read_i(z_high_read),
		.lock_off_i(lock_off_q),
		.low_byte_o(z_low_byte),
		.high_byte_o(z_high_byte)
	);

	////////////////////////////////////////////////////////////////////////////////
	// read mux and error decode

	reg [7:0] rd_mux;
	reg rd_hit;
	reg wr_hit;

	// address decode; undefined indices and writes to read-only words are errors
	always @* begin
		rd_mux = 8'h00;
		rd_hit = 1'b1;
		wr_hit = 1'b0;
		if (idx == `IDX_X_LOW) begin
			rd_mux = x_low_byte;
		end else if (idx == `IDX_X_HIGH) begin
			rd_mux = x_high_byte;
		end else if (idx == `IDX_Y_LOW) begin
			rd_mux = y_low_byte;
		end else if (idx == `IDX_Y_HIGH) begin
			rd_mux = y_high_byte;
		end else if (idx == `IDX_Z_LOW) begin
			rd_mux = z_low_byte;
		end else if (idx == `IDX_Z_HIGH) begin
			rd_mux = z_high_byte;
		end else if (idx == `IDX_CTRL) begin
			rd_mux = {7'h00, lock_off_q};
			wr_hit = 1'b1;
		end else if (idx == `IDX_IRQ_STATUS) begin
			rd_mux = {5'h00, irq_status_q};
		end else if (idx == `IDX_IRQ_CLEAR) begin
			rd_mux = 8'h00;
			wr_hit = 1'b1;
		end else if (idx == `IDX_IRQ_ENABLE) begin
			rd_mux = {5'h00, irq_enable_q};
			wr_hit = 1'b1;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// read data and error captured in setup so both come from flops in access
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_o <= `RST_RDATA;
			pslverr_o <= 1'b0;
		end else if (setup_phase) begin
			prdata_o <= pwrite_i ? `RST_RDATA : {24'h000000, rd_mux};
			pslverr_o <= pwrite_i ? ~wr_hit : ~rd_hit;
		end else if (~psel_i) begin
			pslverr_o <= 1'b0;
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////////////
// one axis: live sample, frozen high byte, shadow lock and fresh flag

module accel_axis_slot (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire load_i,
	input wire [11:0] sample_i,
	input wire low_setup_i,
	input wire low_read_i,
	input wire high_read_i,
	input wire lock_off_i,
	output wire [7:0] low_byte_o,
	output wire [7:0] high_byte_o
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	reg [11:0] live_q;
	reg [7:0] frozen_q;
	reg lock_q;
	reg fresh_q;
	reg fresh_d;
	reg lock_d;

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic

	// fresh flag: readout clears, update sets; update wins so a sample landing
	// in the readout cycle is never reported as old
	always @* begin
		fresh_d = fresh_q;
		if (low_read_i) begin
			fresh_d = 1'b0;
		end
		if (load_i) begin
			fresh_d = 1'b1;
		end
	end

	// lock: taken on a low read, dropped by any high read; a second low read
	// before the high one re-arms it with a newer frozen copy
	always @* begin
		lock_d = lock_q;
		if (high_read_i) begin
			lock_d = 1'b0;
		end
		if (low_read_i & ~lock_off_i) begin
			lock_d = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			live_q <= `RST_SAMPLE;
			frozen_q <= `RST_HIGH;
			lock_q <= 1'b0;
			fresh_q <= 1'b0;
		end else begin
			lock_q <= lock_d;
			fresh_q <= fresh_d;
			if (load_i) begin
				live_q <= sample_i;
			end
			// copy at setup, the cycle in which the low byte itself is sampled
			if (low_setup_i & ~lock_off_i) begin
				frozen_q <= live_q[`SAMPLE_HIGH_MSB:`SAMPLE_HIGH_LSB];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read views

	// low byte: sample 3:0 on top; the undefined bits read as zero
	assign low_byte_o = {live_q[`SAMPLE_LOW_MSB:`SAMPLE_LOW_LSB], 3'h0, fresh_q};
	// high byte: frozen copy while locked, else the newest sample; setting
	// lock-off shows the live value at once, even with a lock pending
	assign high_byte_o = (lock_q & ~lock_off_i) ? frozen_q :
		live_q[`SAMPLE_HIGH_MSB:`SAMPLE_HIGH_LSB];

endmodule

// ### verilog/accel_readout_defines.vh
// register indices, field positions and reset values of the acceleration readout bank
`ifndef ACCEL_READOUT_DEFINES_VH
`define ACCEL_READOUT_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_X_LOW 6'h02
`define IDX_X_HIGH 6'h03
`define IDX_Y_LOW 6'h04
`define IDX_Y_HIGH 6'h05
`define IDX_Z_LOW 6'h06
`define IDX_Z_HIGH 6'h07
`define IDX_CTRL 6'h10
`define IDX_IRQ_STATUS 6'h11
`define IDX_IRQ_CLEAR 6'h12
`define IDX_IRQ_ENABLE 6'h13

// index field of the byte address
`define ADDR_IDX_MSB 7
`define ADDR_IDX_LSB 2

// sample layout
`define SAMPLE_W 12
`define SAMPLE_HIGH_MSB 11
`define SAMPLE_HIGH_LSB 4
`define SAMPLE_LOW_MSB 3
`define SAMPLE_LOW_LSB 0
`define LOW_FRESH_BIT 0
`define NUM_AXES 3

// control register fields
`define CTRL_LOCK_OFF_BIT 0

// reset values
`define RST_LOCK_OFF 1'b0
`define RST_SAMPLE 12'h000
`define RST_HIGH 8'h00
`define RST_IRQ 3'h0
`define RST_RDATA 32'h0000_0000

`endif

// ### bench/accel_readout_props.sv
// port assertions of the readout bank
`timescale 1ns/1ps
module accel_readout_props (
	input clk_sys_i,
	input sys_rst_i,
	input psel_i,
	input penable_i,
	input pwrite_i,
	input [7:0] paddr_i,
	input pready_o,
	input [31:0] prdata_o,
	input pslverr_o,
	input [2:0] sample_valid_i,
	input irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// setup decodes; x low read with no load
	wire rs = psel_i && !penable_i && !pwrite_i;
	wire vx = sample_valid_i[0];
	wire xa = rs && paddr_i == 8'h08;
	wire xl = xa && !vx;
	wire cause = |sample_valid_i || psel_i && pwrite_i;
	chk_ready_tied: assert property (pready_o) else $error("ready");
	chk_fresh_set: assert property (vx ##1 xa |=> prdata_o[0]) else $error("fresh");
	chk_fresh_clr: assert property (xl ##1 (penable_i && !vx) ##1 xl |=> !prdata_o[0])
		else $error("stale");
	chk_low_pad: assert property (xa |=> prdata_o[3:1] == 3'h0) else $error("pad");
	chk_bad_read: assert property (rs && paddr_i > 8'h4f |=> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped");
	chk_ro_write: assert property (psel_i && !penable_i && pwrite_i && paddr_i == 8'h0c
		|=> pslverr_o) else $error("ro");
	chk_err_drop: assert property (!psel_i |=> !pslverr_o) else $error("err");
	chk_irq_cause: assert property ($rose(irq_o) |-> $past(cause)) else $error("irq");
	cover property (xa ##[1:9] rs && paddr_i == 8'h0c);
	cover property (pslverr_o);
	cover property ($rose(irq_o));
endmodule
bind accel_sample_readout_regs accel_readout_props u_props (.*);

// ### bench/host_apb_model.sv
// host model driving apb transfers
`timescale 1ns/1ps
module host_apb_model (
	input wire clk_sys_i,
	input wire pready_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o
);
	initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = 43'h0;
	// held until ready; caller reads low first, never in reset
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		{psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} <= {2'h2, w, a, d};
		@(posedge clk_sys_i);
		penable_o <= 1'h1;
		@(posedge clk_sys_i);
		while (!pready_i) @(posedge clk_sys_i);
	endtask
	task idle;
		{psel_o, penable_o} <= 2'h0;
		@(posedge clk_sys_i);
	endtask
endmodule

// ### bench/accel_sample_readout_regs_tb_top.sv
// self-checking bench of the readout bank
`timescale 1ns/1ps
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin n_fail++; \
	$display("mismatch %0t %h %h", $time, g, x); end end
module accel_sample_readout_regs_tb_top;
	logic clk_sys_i = 1'h0, sys_rst_i = 1'h1;
	logic [35:0] smp = 36'h0;
	logic [2:0] sample_valid_i = 3'h0;
	logic [11:0] a0, a1;
	logic [7:0] b;
	logic [32:0] q[$], e;
	integer n_fail = 0, total_checks = 0, cyc = 0, seed = 32'hf9c04759;
	wire psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
	wire [7:0] paddr_i;
	wire [31:0] pwdata_i, prdata_o;
	wire [3:0] pstrb_i = 4'hf;
	wire [11:0] sample_x_i = smp[11:0], sample_y_i = smp[23:12], sample_z_i = smp[35:24];
	initial forever #4 clk_sys_i = ~clk_sys_i;
	accel_sample_readout_regs dut (.*);
	host_apb_model u_host (.clk_sys_i, .pready_i(pready_o), .psel_o(psel_i), .penable_o(penable_i),
		.pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
	// note {error, byte}, then run the transfer
	task rd(input logic [7:0] a, input logic [8:0] x);
		q.push_back({x[8], 24'h0, x[7:0]});
		u_host.xfer(1'h0, a, 32'h0);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d, input logic x);
		q.push_back({x, 32'h0});
		u_host.xfer(1'h1, a, {24'h0, d});
	endtask
	task load(input integer a, input logic [11:0] v);
		smp[a*12+:12] <= v;
		sample_valid_i <= 3'h1 << a;
		@(posedge clk_sys_i);
		sample_valid_i <= 3'h0;
	endtask
	task report_and_stop;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// oldest note against each access beat; ceiling cuts a hang
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			report_and_stop;
		end
		if (psel_i && penable_i && pready_o) begin
			e = q.pop_front();
			`CHK({pslverr_o, pwrite_i ? 32'h0 : prdata_o}, e)
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys_i);
		sys_rst_i <= 1'h0;
		@(posedge clk_sys_i);
		wr(8'h4c, 8'h7, 1'h0);
		u_host.idle;
		for (int i = 0; i < 3; i++) begin
			{a1, a0} = 24'($random(seed));
			b = 8'(8 * i + 8);
			load(i, a0);
			rd(b, {1'h0, a0[3:0], 4'h1});
			u_host.idle;
			load(i, a1);
			rd(b + 8'h4, {1'h0, a0[11:4]});
			rd(b + 8'h4, {1'h0, a1[11:4]});
			rd(b, {1'h0, a1[3:0], 4'h1});
			rd(b, {1'h0, a1[3:0], 4'h0});
			u_host.idle;
		end
		rd(8'h44, 9'h7);
		u_host.idle;
		@(negedge clk_sys_i);
		`CHK(irq_o, 1'h1)
		@(posedge clk_sys_i);
		wr(8'h48, 8'h7, 1'h0);
		wr(8'h4c, 8'h0, 1'h0);
		u_host.idle;
		load(1, a1);
		@(negedge clk_sys_i);
		`CHK(irq_o, 1'h0)
		@(posedge clk_sys_i);
		rd(8'h44, 9'h2);
		rd(8'hfc, 9'h100);
		wr(8'h0c, 8'h5, 1'h1);
		u_host.idle;
		// lock-off mode: high shows the newest sample despite a low read
		wr(8'h40, 8'h1, 1'h0);
		rd(8'h40, 9'h1);
		u_host.idle;
		load(0, a0);
		rd(8'h08, {1'h0, a0[3:0], 4'h1});
		u_host.idle;
		load(0, a1);
		rd(8'h0c, {1'h0, a1[11:4]});
		wr(8'h40, 8'h0, 1'h0);
		u_host.idle;
		`CHK(q.size(), 0)
		report_and_stop;
	end
endmodule
